// ---- design/aic_pkg.sv ----
// constants and types shared by the amplifier control port
package aic_pkg;

// ****************************************
// Overview of operation
// RULE_01: device is slave only; never stretches SCL nor inserts wait states.
// RULE_02: link runs at up to 100 kbps for every transfer type.
// RULE_03: bytes of eight bits, MSB first, each acknowledged by a ninth bit.
// RULE_04: device pulls SDA low through the acknowledge clock of accepted bytes.
// RULE_05: master opens with start, closes with stop releasing the bus.
// RULE_06: SDA changes only while SCL is low, except start and stop.
// RULE_07: SDA and SCL are open drain; sides only pull low or release.
// RULE_08: first byte is seven-bit address plus direction; five bits fixed.
// RULE_09: two address bits from strap give write addresses D8 to DE.
// RULE_10: strap also picks oscillator role: ground leads, others follow.
// RULE_11: sync pin aligns oscillators of linked devices or takes external clock.
// RULE_12: direction bit 0 writes, 1 starts a read back.
// RULE_13: single write: address, subaddress, data, each acknowledged, then stop.
// RULE_14: after each acknowledged write byte subaddress advances by one.
// RULE_15: single read: subaddress write, repeated start, read address, one byte.
// RULE_16: master acknowledges all but last read byte; subaddress advances.
// RULE_17: fault registers are read one at a time, no auto increment.
// RULE_18: any number of data bytes between start and stop.
// RULE_19: every fault and detection is reported in pollable registers.
// RULE_20: each channel gain settable to 12, 20, 26 or 32 dB.
// RULE_21: master can put one channel in high impedance as a mute.
// RULE_22: master can clear faults and leave high impedance as an unmute.
// RULE_23: subaddresses 00 to 07 read only status, 08 to 0F control.
// RULE_24: unmatched address gets no acknowledge; bus ignored until next start.
// RULE_25: one subaddress byte follows write address, sets start register.
// ****************************************

localparam logic [4:0] DEV_ADDR_FIXED = 5'h1B;
localparam int REG_COUNT = 16;
localparam logic [7:0] SUB_FAULT_LAST = 8'h03;
localparam logic [7:0] SUB_CTRL_FIRST = 8'h08;
localparam logic [7:0] SUB_LAST = 8'h0F;
localparam logic [7:0] SUB_GAIN = 8'h08;
localparam logic [7:0] SUB_OUTSTATE = 8'h0C;
localparam int OUTSTATE_CLEAR_BIT = 4;

// apb map: register n of the map sits at byte address 4*n
localparam logic [11:0] APB_PORT_STATUS = 12'h040;
localparam logic [11:0] APB_PORT_CTRL = 12'h044;
localparam logic PORT_EN_RESET = 1'h1;
localparam int ST_STRAP_LSB = 0;
localparam int ST_LEADER = 2;
localparam int ST_BUSY = 3;
localparam int ST_ADDRESSED = 4;

// leader drives the sync pin at this rate
localparam int SYS_CLK_KHZ = 100000;
localparam int SYNC_FREQ_KHZ = 250;
localparam logic [7:0] SYNC_HALF_CYCLES = 8'(SYS_CLK_KHZ / (2 * SYNC_FREQ_KHZ));
localparam logic [1:0] STRAP_SETTLE = 2'h3;
localparam logic [1:0] STRAP_LEADER = 2'h0;

typedef enum logic [3:0] {
   ST_IDLE = 4'h0,
   ST_ADDR = 4'h1,
   ST_SUB = 4'h2,
   ST_WDATA = 4'h3,
   ST_WACK = 4'h4,
   ST_RLOAD = 4'h5,
   ST_RDATA = 4'h6,
   ST_RACK = 4'h7,
   ST_IGNORE = 4'h8
} aic_state_type;

typedef enum logic [1:0] {
   GAIN_12DB = 2'h0,
   GAIN_20DB = 2'h1,
   GAIN_26DB = 2'h2,
   GAIN_32DB = 2'h3
} aic_gain_type;

typedef struct packed {
   logic en;
   logic [3:0] addr;
   logic [7:0] data;
} aic_wr_type;

typedef logic [7:0][7:0] aic_bank_type;

endpackage

// ---- design/aic_regfile.sv ----
// sixteen byte register file with two write and two registered read ports
`timescale 1ns/1ns
module aic_regfile
   import aic_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write ports, port a wins on the same address
   input wire aic_wr_type wr_a,
   input wire aic_wr_type wr_b,
   // read ports
   input wire logic [3:0] raddr_a,
   input wire logic [3:0] raddr_b,
   output logic [7:0] rdata_a,
   output logic [7:0] rdata_b,
   // control bytes 08 to 0F
   output aic_bank_type ctrl_bank
);

logic [7:0] mem_reg [REG_COUNT];
logic [7:0] mem_next [REG_COUNT];
logic [7:0] rda_reg;
logic [7:0] rdb_reg;

always_comb begin
   for (int i = 0; i < REG_COUNT; i++) begin
      mem_next[i] = mem_reg[i];
   end
   if (wr_b.en) begin
      mem_next[wr_b.addr] = wr_b.data;
   end
   if (wr_a.en) begin
      mem_next[wr_a.addr] = wr_a.data;
   end
end

always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
         mem_reg[i] <= 8'h00;
      end
      rda_reg <= 8'h00;
      rdb_reg <= 8'h00;
   end else begin
      for (int i = 0; i < REG_COUNT; i++) begin
         mem_reg[i] <= mem_next[i];
      end
      rda_reg <= mem_reg[raddr_a];
      rdb_reg <= mem_reg[raddr_b];
   end
end

assign rdata_a = rda_reg;
assign rdata_b = rdb_reg;

always_comb begin
   for (int i = 0; i < 8; i++) begin
      ctrl_bank[i] = mem_reg[i + 8];
   end
end

endmodule

// ---- design/aic_control_port.sv ----
// serial control port slave with apb side access
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module aic_control_port
   import aic_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address strap
   input wire logic [1:0] strap_level,
   // oscillator sync pin
   input wire logic oscillator_sync_pin_in,
   output logic oscillator_sync_pin_out,
   output logic oscillator_sync_pin_oe,
   // amplifier controls
   output logic oscillator_leader_role,
   output logic sync_tick,
   output aic_gain_type [3:0] channel_gain,
   output logic [3:0] channel_hiz,
   output logic fault_clear,
   output aic_bank_type ctrl_bank
);

// ****************************************
// pin synchronisers and edge detect
// ****************************************
logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
logic [1:0] strap_s1_reg, strap_s2_reg;
logic start_ev, stop_ev, rise_ev, fall_ev;

// 10 ns sampling far outruns a 100 kbps link
always_ff @(posedge pclk or negedge presetn) begin // RULE_02
   if (!presetn) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
   end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      osc_s1_reg <= oscillator_sync_pin_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      strap_s1_reg <= strap_level;
      strap_s2_reg <= strap_s1_reg;
   end
end

assign start_ev = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg; // RULE_05
assign stop_ev = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg; // RULE_05
assign rise_ev = scl_s2_reg && !scl_s3_reg;
assign fall_ev = !scl_s2_reg && scl_s3_reg;

// ****************************************
// strap capture and oscillator role
// ****************************************
logic [1:0] strap_wait_reg, strap_wait_next;
logic [1:0] strap_code_reg, strap_code_next;
logic strap_done_reg, strap_done_next;
logic [7:0] div_reg, div_next;
logic osc_out_reg, osc_out_next;
logic osc_oe_reg, osc_oe_next;
logic leader_reg, leader_next;
logic tick_reg, tick_next;
logic [6:0] own_addr;

assign own_addr = {DEV_ADDR_FIXED, strap_code_reg}; // RULE_08 RULE_09

always_comb begin
   strap_wait_next = strap_wait_reg;
   strap_code_next = strap_code_reg;
   strap_done_next = strap_done_reg;
   div_next = div_reg;
   osc_out_next = osc_out_reg;
   tick_next = 1'b0;
   if (!strap_done_reg) begin
      strap_wait_next = strap_wait_reg + 2'h1;
      if (strap_wait_reg == STRAP_SETTLE) begin
         strap_code_next = strap_s2_reg;
         strap_done_next = 1'b1;
      end
   end
   leader_next = strap_done_reg && (strap_code_reg == STRAP_LEADER); // RULE_10
   osc_oe_next = leader_next;
   if (leader_reg) begin // RULE_11
      div_next = div_reg + 8'h01;
      if (div_reg == SYNC_HALF_CYCLES - 8'h01) begin
         div_next = 8'h00;
         osc_out_next = !osc_out_reg;
         tick_next = !osc_out_reg;
      end
   end else begin
      tick_next = strap_done_reg && osc_s2_reg && !osc_s3_reg; // RULE_11
   end
end

always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      strap_wait_reg <= 2'h0;
      strap_code_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      div_reg <= 8'h00;
      osc_out_reg <= 1'b0;
      osc_oe_reg <= 1'b0;
      leader_reg <= 1'b0;
      tick_reg <= 1'b0;
   end else begin
      strap_wait_reg <= strap_wait_next;
      strap_code_reg <= strap_code_next;
      strap_done_reg <= strap_done_next;
      div_reg <= div_next;
      osc_out_reg <= osc_out_next;
      osc_oe_reg <= osc_oe_next;
      leader_reg <= leader_next;
      tick_reg <= tick_next;
   end
end

// ****************************************
// serial link engine
// ****************************************
aic_state_type st_reg, st_next, ackto_reg, ackto_next;
logic [2:0] cnt_reg, cnt_next;
logic full_reg, full_next;
logic [7:0] shift_reg, shift_next;
logic [7:0] tx_reg, tx_next;
logic [7:0] sub_reg, sub_next;
logic sda_oe_reg, sda_oe_next;
logic fclr_reg, fclr_next;
logic port_en_reg, port_en_next;
logic [7:0] rdata_a;
logic [7:0] rdata_b;
logic [7:0] load_byte;
aic_wr_type i2c_wr, apb_wr;

always_comb begin
   st_next = st_reg;
   ackto_next = ackto_reg;
   cnt_next = cnt_reg;
   full_next = full_reg;
   shift_next = shift_reg;
   tx_next = tx_reg;
   sub_next = sub_reg;
   sda_oe_next = sda_oe_reg;
   fclr_next = 1'b0;
   i2c_wr = '0;
   load_byte = (sub_reg[7:4] == 4'h0) ? rdata_a : 8'h00;
   if (start_ev) begin // RULE_05
      st_next = ST_ADDR;
      cnt_next = 3'h0;
      full_next = 1'b0;
      sda_oe_next = 1'b0;
   end else if (stop_ev) begin
      st_next = ST_IDLE;
      sda_oe_next = 1'b0;
   end else begin
      case (st_reg)
         ST_ADDR, ST_SUB, ST_WDATA: begin
            if (rise_ev && !full_reg) begin // RULE_03
               shift_next = {shift_reg[6:0], sda_s2_reg};
               cnt_next = cnt_reg + 3'h1;
               full_next = (cnt_reg == 3'h7);
            end else if (fall_ev && full_reg) begin // RULE_06
               full_next = 1'b0;
               cnt_next = 3'h0;
               sda_oe_next = 1'b1; // RULE_04
               st_next = ST_WACK;
               case (st_reg)
                  ST_ADDR: begin
                     if (shift_reg[7:1] != own_addr || !port_en_reg || !strap_done_reg) begin
                        sda_oe_next = 1'b0; // RULE_24
                        st_next = ST_IGNORE;
                     end else if (shift_reg[0]) begin // RULE_12
                        st_next = ST_RLOAD; // RULE_15
                     end else begin
                        ackto_next = ST_SUB; // RULE_25
                     end
                  end
                  ST_SUB: begin
                     sub_next = shift_reg; // RULE_25 RULE_13
                     ackto_next = ST_WDATA;
                  end
                  default: begin
                     ackto_next = ST_WDATA; // RULE_18
                     if (sub_reg >= SUB_CTRL_FIRST && sub_reg <= SUB_LAST) begin // RULE_23
                        i2c_wr = '{en: 1'b1, addr: sub_reg[3:0], data: shift_reg}; // RULE_13
                        fclr_next = (sub_reg == SUB_OUTSTATE) &&
                           shift_reg[OUTSTATE_CLEAR_BIT]; // RULE_22
                     end
                     sub_next = sub_reg + 8'h01; // RULE_14
                  end
               endcase
            end
         end
         ST_WACK: begin
            if (fall_ev) begin // RULE_04
               sda_oe_next = 1'b0;
               st_next = ackto_reg;
            end
         end
         ST_RLOAD: begin
            if (fall_ev) begin // RULE_06
               tx_next = load_byte;
               sda_oe_next = !load_byte[7]; // RULE_07
               cnt_next = 3'h0;
               full_next = 1'b0;
               st_next = ST_RDATA;
            end
         end
         ST_RDATA: begin
            if (rise_ev && !full_reg) begin
               cnt_next = cnt_reg + 3'h1;
               full_next = (cnt_reg == 3'h7);
            end else if (fall_ev) begin
               if (full_reg) begin
                  sda_oe_next = 1'b0;
                  full_next = 1'b0;
                  st_next = ST_RACK;
                  if (sub_reg > SUB_FAULT_LAST) begin // RULE_17
                     sub_next = sub_reg + 8'h01; // RULE_16
                  end
               end else begin
                  tx_next = {tx_reg[6:0], 1'b0}; // RULE_03
                  sda_oe_next = !tx_reg[6];
               end
            end
         end
         ST_RACK: begin
            if (rise_ev) begin // RULE_16
               st_next = sda_s2_reg ? ST_IGNORE : ST_RLOAD;
            end
         end
         default: begin
            sda_oe_next = 1'b0;
         end
      endcase
   end
end

always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      st_reg <= ST_IDLE;
      ackto_reg <= ST_SUB;
      cnt_reg <= 3'h0;
      full_reg <= 1'b0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      sub_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      fclr_reg <= 1'b0;
   end else begin
      st_reg <= st_next;
      ackto_reg <= ackto_next;
      cnt_reg <= cnt_next;
      full_reg <= full_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      sub_reg <= sub_next;
      sda_oe_reg <= sda_oe_next;
      fclr_reg <= fclr_next;
   end
end

// open drain: only ever pull low, SCL never driven
assign sda_out = 1'b0; // RULE_07
assign sda_oe = sda_oe_reg;
assign scl_out = 1'b0;
assign scl_oe = 1'b0; // RULE_01

// ****************************************
// register file
// ****************************************
aic_bank_type bank;

aic_regfile u_regfile (
   .pclk(pclk),
   .presetn(presetn),
   .wr_a(i2c_wr),
   .wr_b(apb_wr),
   .raddr_a(sub_reg[3:0]),
   .raddr_b(paddr[5:2]),
   .rdata_a(rdata_a),
   .rdata_b(rdata_b),
   .ctrl_bank(bank)
);

// ****************************************
// apb slave
// ****************************************
logic [31:0] prdata_reg, prdata_next;
logic pready_reg, pready_next;
logic pslverr_reg, pslverr_next;
logic busy_reg, busy_next;
logic in_regs, apb_acc;
logic [31:0] status_word;

assign in_regs = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
assign apb_acc = psel && penable && !pready_reg;

always_comb begin
   status_word = 32'h0000_0000;
   status_word[ST_STRAP_LSB +: 2] = strap_code_reg;
   status_word[ST_LEADER] = leader_reg;
   status_word[ST_BUSY] = (st_reg != ST_IDLE);
   status_word[ST_ADDRESSED] = (st_reg != ST_IDLE) && (st_reg != ST_IGNORE) &&
      (st_reg != ST_ADDR);
end

always_comb begin
   prdata_next = prdata_reg;
   pready_next = 1'b0;
   pslverr_next = 1'b0;
   busy_next = busy_reg;
   port_en_next = port_en_reg;
   apb_wr = '0;
   if (apb_acc && !busy_reg) begin
      busy_next = 1'b1;
   end else if (apb_acc) begin
      busy_next = 1'b0;
      pready_next = 1'b1;
      if (pwrite) begin
         // only status bytes and port control are writable from this side
         pslverr_next = !((in_regs && !paddr[5]) || paddr == APB_PORT_CTRL);
      end else if (in_regs) begin
         prdata_next = {24'h000000, rdata_b}; // RULE_19
      end else if (paddr == APB_PORT_STATUS) begin
         prdata_next = status_word;
      end else if (paddr == APB_PORT_CTRL) begin
         prdata_next = {31'h00000000, port_en_reg};
      end else begin
         prdata_next = 32'h0000_0000;
         pslverr_next = 1'b1;
      end
   end
   if (pready_reg && psel && penable && pwrite && !pslverr_reg) begin
      if (paddr == APB_PORT_CTRL) begin
         port_en_next = pwdata[0];
      end else begin
         apb_wr = '{en: 1'b1, addr: paddr[5:2], data: pwdata[7:0]}; // RULE_19 RULE_23
      end
   end
end

always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      busy_reg <= 1'b0;
      port_en_reg <= PORT_EN_RESET;
   end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      busy_reg <= busy_next;
      port_en_reg <= port_en_next;
   end
end

assign prdata = prdata_reg;
assign pready = pready_reg;
assign pslverr = pslverr_reg;

// ****************************************
// amplifier control outputs
// ****************************************
aic_bank_type ctrl_reg;
aic_gain_type [3:0] gain_reg;
logic [3:0] hiz_reg;

always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      ctrl_reg <= '0;
      gain_reg <= {4{GAIN_12DB}};
      hiz_reg <= 4'h0;
   end else begin
      ctrl_reg <= bank;
      for (int i = 0; i < 4; i++) begin
         gain_reg[i] <= aic_gain_type'(bank[SUB_GAIN[2:0]][2 * i +: 2]); // RULE_20
      end
      hiz_reg <= bank[SUB_OUTSTATE[2:0]][3:0]; // RULE_21 RULE_22
   end
end

assign ctrl_bank = ctrl_reg;
assign channel_gain = gain_reg;
assign channel_hiz = hiz_reg;
assign fault_clear = fclr_reg;
assign oscillator_sync_pin_out = osc_out_reg;
assign oscillator_sync_pin_oe = osc_oe_reg;
assign oscillator_leader_role = leader_reg;
assign sync_tick = tick_reg;

endmodule

// ---- sim/aic_control_port_properties.sv ----
// concurrent checks on the pins of the amplifier control port
`timescale 1ns/1ns
module aic_control_port_properties
   import aic_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // serial link
   input wire logic scl_in,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   // strap and roles
   input wire logic [1:0] strap_level,
   input wire logic oscillator_leader_role,
   input wire logic oscillator_sync_pin_oe,
   input wire logic oscillator_sync_pin_out,
   // amplifier controls
   input wire aic_gain_type [3:0] channel_gain,
   input wire logic [3:0] channel_hiz,
   input wire logic fault_clear,
   input wire aic_bank_type ctrl_bank
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ********
   // settle counter after reset
   // ********
   logic [3:0] settle_reg;
   logic [3:0] settle_next;
   always_comb begin
      settle_next = settle_reg;
      if (settle_reg != 4'hF) begin
         settle_next = settle_reg + 4'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_reg <= 4'h0;
      end else begin
         settle_reg <= settle_next;
      end
   end
   // ********
   // properties
   // ********
   AST_NO_STRETCH: assert property (scl_oe == 1'b0)
      else $error("scl driven");
   AST_PULL_ONLY: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("sda driven high");
   AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda moved while scl high");
   AST_ACK_STANDS: assert property ($rose(sda_oe) |-> sda_oe [*8])
      else $error("sda bit too short");
   AST_LEADER: assert property (settle_reg == 4'hF |->
      oscillator_leader_role == (strap_level == 2'h0))
      else $error("role not from strap");
   AST_SYNC_OE: assert property (settle_reg == 4'hF |->
      oscillator_sync_pin_oe == oscillator_leader_role)
      else $error("sync enable not role");
   AST_SYNC_RUN: assert property (oscillator_leader_role |->
      ##[1:200] $changed(oscillator_sync_pin_out))
      else $error("sync pin stalled");
   AST_GAIN: assert property ($changed(ctrl_bank[0]) |->
      ##[0:2] 8'(channel_gain) == ctrl_bank[0])
      else $error("gain not from byte");
   AST_HIZ: assert property ($changed(ctrl_bank[4][3:0]) |->
      ##[0:2] channel_hiz == ctrl_bank[4][3:0])
      else $error("hiz not from byte");
   AST_CLEAR: assert property (fault_clear |-> ##[0:2] ctrl_bank[4][4])
      else $error("clear without bit");
   AST_CLEAR_PULSE: assert property (fault_clear |=> !fault_clear)
      else $error("clear too long");
   AST_APB_ANSWER: assert property (psel && penable && !$past(penable) |-> ##2 pready)
      else $error("register answer late");
endmodule

// ---- sim/aic_bus_master_model.sv ----
// serial bus master model standing in for the system processor
`timescale 1ns/1ns
module aic_bus_master_model (
   // wire level
   input wire logic sda,
   // pull-low controls
   output logic scl_low,
   output logic sda_low
);
   int gap = 0;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // ********
   // conditions, bits and bytes
   // ********
   task automatic start();
      #31 sda_low = 1'b0;
      #32 scl_low = 1'b0;
      #62 sda_low = 1'b1;
      #62 scl_low = 1'b1;
   endtask
   task automatic stop();
      #31 sda_low = 1'b1;
      #32 scl_low = 1'b0;
      #62 sda_low = 1'b0;
      #62;
   endtask
   task automatic bit_cycle(input logic b, output logic r);
      #31 sda_low = !b;
      #(32 + gap) scl_low = 1'b0;
      #31 r = sda;
      #31 scl_low = 1'b1;
   endtask
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], r);
      end
      bit_cycle(1'b1, r);
      ack = !r;
   endtask
   task automatic get(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, r);
         d[i] = r;
      end
      bit_cycle(!ack, r);
   endtask
endmodule

// ---- sim/aic_control_port_tb.sv ----
// self-checking testbench of the amplifier control port
`timescale 1ns/1ns
module aic_control_port_tb;
   import aic_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low;
   logic [1:0] strap = 2'h0;
   logic sync_out, sync_oe, leader, fault_clear, scl_w, sda_w, sync_w;
   logic [3:0] channel_hiz;
   aic_gain_type [3:0] channel_gain;
   logic [7:0] dev_w;
   int failures = 0, cmp_count = 0, fc_count = 0;
   always #5 pclk = ~pclk;
   assign scl_w = !m_scl_low;
   assign sda_w = !(m_sda_low || (sda_oe && !sda_out));
   assign sync_w = sync_oe ? sync_out : 1'b0;
   always @(posedge pclk) if (fault_clear === 1'b1) fc_count++;
   aic_control_port i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe,
      .strap_level(strap), .oscillator_sync_pin_in(sync_w), .oscillator_sync_pin_out(sync_out),
      .oscillator_sync_pin_oe(sync_oe), .oscillator_leader_role(leader), .sync_tick(),
      .channel_gain, .channel_hiz, .fault_clear, .ctrl_bank());
   aic_bus_master_model i_mst (.sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));
   // ********
   // shared tasks
   // ********
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic reset(input logic [1:0] s);
      @(posedge pclk);
      presetn <= 1'b0;
      strap <= s;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      dev_w = 8'hD8 + {5'h0, s, 1'b0};
      repeat (12) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) begin
         failures++;
         conclude();
      end
   endtask
   task automatic lwr(input logic [7:0] sub, input logic [7:0] d[$]);
      logic a;
      i_mst.start();
      i_mst.put(dev_w, a);
      chk("address ack", 1, a);
      i_mst.put(sub, a);
      chk("subaddress ack", 1, a);
      foreach (d[i]) begin
         i_mst.put(d[i], a);
         chk("data ack", 1, a);
      end
      i_mst.stop();
   endtask
   task automatic lrd(input logic [7:0] sub, input int n, output logic [15:0] r);
      logic a;
      logic [7:0] b;
      i_mst.start();
      i_mst.put(dev_w, a);
      i_mst.put(sub, a);
      i_mst.start();
      i_mst.put(dev_w | 8'h01, a);
      chk("read address ack", 1, a);
      r = 16'h0;
      for (int i = 0; i < n; i++) begin
         i_mst.get(i < n - 1, b);
         r = {r[7:0], b};
      end
      i_mst.stop();
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_fault();
      logic [31:0] q;
      logic e;
      logic [15:0] r;
      apb(1'b1, 12'h000, 32'h5A, q, e);
      apb(1'b1, 12'h004, 32'hC3, q, e);
      apb(1'b1, 12'h010, 32'h11, q, e);
      apb(1'b1, 12'h014, 32'h22, q, e);
      apb(1'b0, APB_PORT_CTRL, 32'h0, q, e);
      chk("port enable", 32'h1, q);
      apb(1'b0, 12'h100, 32'h0, q, e);
      chk("unmapped error", 1, e);
      i_mst.gap = 300;
      lrd(8'h00, 2, r);
      chk("fault reread", 32'h5A5A, r);
      i_mst.gap = 0;
      lwr(8'h01, '{8'hFF});
      apb(1'b0, 12'h004, 32'h0, q, e);
      chk("read only byte", 32'hC3, q);
      lrd(8'h04, 2, r);
      chk("status sequence", 32'h1122, r);
      $display("test fault done");
   endtask
   task automatic t_gain();
      int fc;
      logic [31:0] q;
      logic e;
      logic [15:0] r;
      lwr(8'h08, '{8'hE4, 8'h3C});
      chk("gain", 32'hE4, 32'(channel_gain));
      apb(1'b0, 12'h024, 32'h0, q, e);
      chk("next register", 32'h3C, q);
      apb(1'b1, 12'h020, 32'h77, q, e);
      chk("control apb refused", 1, e);
      lrd(8'h08, 1, r);
      chk("single read", 32'hE4, r);
      lrd(8'h08, 2, r);
      chk("sequential read", 32'hE43C, r);
      fc = fc_count;
      lwr(8'h0C, '{8'h15});
      chk("hiz", 32'h5, channel_hiz);
      chk("clear pulses", fc + 1, fc_count);
      lwr(8'h0C, '{8'h00});
      chk("unmute", 32'h0, channel_hiz);
      $display("test gain done");
   endtask
   task automatic t_strap();
      logic a;
      logic [31:0] q;
      logic e;
      for (int s = 0; s < 4; s++) begin
         reset(2'(s));
         chk("leader", s == 0, leader);
         i_mst.start();
         i_mst.put(8'hD8 + 8'(2 * ((s + 1) % 4)), a);
         chk("foreign nack", 0, a);
         i_mst.put(dev_w, a);
         chk("ignored byte", 0, a);
         i_mst.start();
         i_mst.put(dev_w, a);
         chk("own ack", 1, a);
         i_mst.stop();
      end
      apb(1'b0, APB_PORT_STATUS, 32'h0, q, e);
      chk("port status", 32'h3, q);
      apb(1'b1, APB_PORT_CTRL, 32'h0, q, e);
      i_mst.start();
      i_mst.put(dev_w, a);
      chk("disabled nack", 0, a);
      i_mst.stop();
      $display("test strap done");
   endtask
   initial begin
      reset(2'h0);
      t_fault();
      t_gain();
      t_strap();
      conclude();
   end
endmodule
bind aic_control_port aic_control_port_properties i_props (.pclk, .presetn, .psel, .penable,
   .pready, .scl_in, .scl_oe, .sda_out, .sda_oe, .strap_level, .oscillator_leader_role,
   .oscillator_sync_pin_oe, .oscillator_sync_pin_out, .channel_gain, .channel_hiz,
   .fault_clear, .ctrl_bank);
